// File: logic/cwl_watchdog_lpm.sv
// What this block does
// - 8-bit up counter on oscillator clock; expiry at maximum value.
// - reset expiry drives reset output low exactly 512 oscillator cycles.
// - key 0x55 then 0xAA clears the counter; software repeats periodically.
// - disable bit stops the counter; no expiry while disabled.
// - configuration picks reset or wake interrupt on expiry.
// - limp-mode clock active: counter holds its value.
// - lost PLL input clock brings limp clock for CPU and peripherals.
// - in standby only the watchdog keeps running on oscillator clock.
// - watchdog interrupt feeds low-power controller to wake from standby.
// - in idle the watchdog interrupt reaches CPU via interrupt expansion.
// - in halt a watchdog expiry wakes the device by reset.
// - mode field 00 idle, 01 standby, 1x halt.
// - idle keeps all clocks; any enabled interrupt ends it.
// - standby gates CPU and system clocks; reset, wdog, pin, debugger exit.
// - wake-select register picks port A wake lines; others ignored.
// - standby wake line qualified over configured oscillator clocks.
// - wake lines active low; short pulse in standby returns to low-power mode.
// - halt entered only while watchdog clock is active.
// - mode changes never alter output pin states.
// - debug port keeps working while CPU clock is stopped.
`include "cwl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cwl_watchdog_lpm
(
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    input  wire cwl_pkg::cwl_bus_req_type bus_req,
    output var  logic [31:0]              bus_rdata,
    input  wire logic                     osc_tick,
    input  wire logic                     limp_mode,
    input  wire logic                     input_clock_lost,
    input  wire logic                     idle_instr,
    input  wire logic                     cpu_int_pending,
    input  wire logic                     external_reset_pin_n,
    input  wire logic                     debug_wake,
    input  wire logic                     wdog_clock_source,
    input  wire logic [31:0]              gpio_a_n,
    output var  logic                     wdog_reset_pulse_n,
    output var  logic                     wdog_wake_interrupt,
    output var  logic                     interrupt_expansion_wd,
    output var  logic                     limp_clock_sel,
    output var  cwl_pkg::cwl_gate_type    clock_gates,
    output var  logic                     peripheral_run,
    output var  logic                     debug_port_run,
    output var  logic                     lowpower_wake,
    output var  logic [1:0]               lowpower_state
);
    import cwl_pkg::*;

    logic [7:0]    wd_count;
    logic [7:0]    wd_ctrl;
    logic          key_armed;
    logic [9:0]    rst_count;
    logic          wd_int_level;
    logic [8:0]    lowpower_config_reg;
    logic [31:0]   wake_pin_select;
    logic [5:0]    qual_count;
    cwl_state_type state;
    cwl_state_type next_state;
    logic          wd_expire;
    logic          key_wr;
    logic          pin_wake;
    logic          halt_wake;
    logic          standby_wake;
    logic          idle_wake;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
        hit = (a == ref_addr);
    endfunction

    // mode field decode, upper bit alone means halt
    function automatic cwl_state_type mode_of(input logic [1:0] m);
        if (m[1])
        begin
            mode_of = CWL_HALT;
        end
        else if (m[0])
        begin
            mode_of = CWL_STANDBY;
        end
        else
        begin
            mode_of = CWL_IDLE;
        end
    endfunction

    assign key_wr = bus_req.wr && hit(bus_req.addr, `CWL_ADDR_WD_KEY);

    // counter only advances on oscillator ticks and never on the limp clock
    assign wd_expire = osc_tick && !limp_mode && !wd_ctrl[`CWL_WD_CTRL_DIS]
                       && (wd_count == `CWL_WD_MAX);

    // key sequence: any other value breaks the pair
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            key_armed <= 1'b0;
        end
        else if (key_wr)
        begin
            key_armed <= (bus_req.wdata[7:0] == `CWL_KEY_FIRST);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wd_count <= 8'h00;
        end
        else if (key_wr && key_armed && bus_req.wdata[7:0] == `CWL_KEY_SECOND)
        begin
            wd_count <= 8'h00;
        end
        else if (osc_tick && !limp_mode && !wd_ctrl[`CWL_WD_CTRL_DIS])
        begin
            // keeps counting in standby: only block left on oscillator clock
            wd_count <= wd_count + 8'h01;
        end
    end

    // reset pulse counted in oscillator ticks, not system cycles
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rst_count          <= 10'd0;
            wdog_reset_pulse_n <= 1'b1;
        end
        else if (rst_count != 10'd0)
        begin
            if (osc_tick)
            begin
                rst_count <= rst_count - 10'd1;
                if (rst_count == 10'd1)
                begin
                    wdog_reset_pulse_n <= 1'b1;
                end
            end
        end
        else if (wd_expire && !wd_ctrl[`CWL_WD_CTRL_INTMODE])
        begin
            rst_count          <= `CWL_RST_PULSE_CYC;
            wdog_reset_pulse_n <= 1'b0;
        end
    end

    // interrupt level stands until the counter is cleared by the key pair
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wd_int_level <= 1'b0;
        end
        else if (wd_expire && wd_ctrl[`CWL_WD_CTRL_INTMODE])
        begin
            wd_int_level <= 1'b1;
        end
        else if (key_wr && key_armed && bus_req.wdata[7:0] == `CWL_KEY_SECOND)
        begin
            wd_int_level <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wdog_wake_interrupt    <= 1'b0;
            interrupt_expansion_wd <= 1'b0;
        end
        else
        begin
            wdog_wake_interrupt    <= wd_int_level;
            interrupt_expansion_wd <= wd_int_level;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wd_ctrl             <= `CWL_WD_CTRL_RESET;
            lowpower_config_reg <= `CWL_LP_CFG_RESET;
            wake_pin_select     <= 32'h00000000;
        end
        else if (bus_req.wr)
        begin
            if (hit(bus_req.addr, `CWL_ADDR_WD_CTRL))
            begin
                wd_ctrl <= bus_req.wdata[7:0];
            end
            if (hit(bus_req.addr, `CWL_ADDR_LP_CFG))
            begin
                lowpower_config_reg <= bus_req.wdata[8:0];
            end
            if (hit(bus_req.addr, `CWL_ADDR_WAKE_SEL))
            begin
                wake_pin_select <= bus_req.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            bus_rdata <= 32'h00000000;
        end
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                `CWL_ADDR_WD_CTRL:   bus_rdata <= {24'h000000, wd_ctrl};
                `CWL_ADDR_WD_STATUS: bus_rdata <= {22'h000000, wd_int_level,
                                                   !wdog_reset_pulse_n, wd_count};
                `CWL_ADDR_LP_CFG:    bus_rdata <= {23'h000000, lowpower_config_reg};
                `CWL_ADDR_WAKE_SEL:  bus_rdata <= wake_pin_select;
                `CWL_ADDR_LP_STATUS: bus_rdata <= {30'h00000000, state};
                default:             bus_rdata <= 32'h00000000;
            endcase
        end
        else
        begin
            bus_rdata <= 32'h00000000;
        end
    end

    // active-low selected lines; unselected lines are masked off
    assign pin_wake = |(~gpio_a_n & wake_pin_select);

    // qualification restarts on any high glitch, so short pulses never wake from standby
    always_ff @(posedge sys_clk)
    begin
        if (reset || !pin_wake || state == CWL_RUN || state == CWL_IDLE)
        begin
            qual_count <= 6'd0;
        end
        else if (osc_tick && qual_count <= lowpower_config_reg[`CWL_LP_QUAL_MSB:`CWL_LP_QUAL_LSB])
        begin
            qual_count <= qual_count + 6'd1;
        end
    end

    assign standby_wake = !external_reset_pin_n || debug_wake
                          || (wd_int_level && lowpower_config_reg[`CWL_LP_WDWAKE])
                          || (qual_count > lowpower_config_reg[`CWL_LP_QUAL_MSB:`CWL_LP_QUAL_LSB]);
    // halt has no oscillator: pins wake unqualified, watchdog via its reset
    assign halt_wake = !external_reset_pin_n || debug_wake || pin_wake
                       || !wdog_reset_pulse_n;
    assign idle_wake = !external_reset_pin_n || cpu_int_pending || wd_int_level;

    always_comb
    begin
        next_state = state;
        case (state)
            CWL_RUN:
            begin
                if (idle_instr)
                begin
                    next_state = mode_of(lowpower_config_reg[`CWL_LP_MODE_MSB:`CWL_LP_MODE_LSB]);
                    if (next_state == CWL_HALT && !wdog_clock_source)
                    begin
                        next_state = CWL_RUN;
                    end
                end
            end
            CWL_IDLE:
            begin
                if (idle_wake)
                begin
                    next_state = CWL_RUN;
                end
            end
            CWL_STANDBY:
            begin
                if (standby_wake)
                begin
                    next_state = CWL_RUN;
                end
            end
            CWL_HALT:
            begin
                if (halt_wake)
                begin
                    next_state = CWL_RUN;
                end
            end
            default:
            begin
                next_state = CWL_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= CWL_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // gates only; pin drivers are elsewhere and are never touched here
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            clock_gates    <= '{cpu_clock_en: 1'b1, sys_clock_en: 1'b1, osc_pll_en: 1'b1};
            peripheral_run <= 1'b1;
            lowpower_wake  <= 1'b0;
            lowpower_state <= 2'b00;
            debug_port_run <= 1'b1;
            limp_clock_sel <= 1'b0;
        end
        else
        begin
            clock_gates.cpu_clock_en <= (next_state == CWL_RUN) || (next_state == CWL_IDLE);
            clock_gates.sys_clock_en <= (next_state == CWL_RUN) || (next_state == CWL_IDLE);
            clock_gates.osc_pll_en   <= (next_state != CWL_HALT);
            peripheral_run <= (next_state == CWL_RUN) || (next_state == CWL_IDLE);
            lowpower_wake  <= (state != CWL_RUN) && (next_state == CWL_RUN);
            lowpower_state <= next_state;
            debug_port_run <= 1'b1;
            limp_clock_sel <= input_clock_lost;
        end
    end

endmodule

`default_nettype wire

// File: logic/cwl_cfg.svh
`ifndef CWL_CFG_SVH
`define CWL_CFG_SVH

// register offsets on the plain port (byte addresses, one word each)
`define CWL_ADDR_WD_CTRL    8'h00
`define CWL_ADDR_WD_KEY     8'h04
`define CWL_ADDR_WD_STATUS  8'h08
`define CWL_ADDR_LP_CFG     8'h0C
`define CWL_ADDR_WAKE_SEL   8'h10
`define CWL_ADDR_LP_STATUS  8'h14

// watchdog control fields
`define CWL_WD_CTRL_DIS     0
`define CWL_WD_CTRL_INTMODE 1
`define CWL_WD_CTRL_RESET   8'h00

// low-power config fields
`define CWL_LP_MODE_LSB     0
`define CWL_LP_MODE_MSB     1
`define CWL_LP_QUAL_LSB     2
`define CWL_LP_QUAL_MSB     7
`define CWL_LP_WDWAKE       8
`define CWL_LP_CFG_RESET    9'h000

`define CWL_KEY_FIRST       8'h55
`define CWL_KEY_SECOND      8'hAA
`define CWL_WD_MAX          8'hFF

// reset pulse length in oscillator clocks
`define CWL_RST_PULSE_CYC   10'd512

`endif

// File: logic/cwl_pkg.sv
package cwl_pkg;

    typedef enum logic [1:0]
    {
        CWL_RUN     = 2'b00,
        CWL_IDLE    = 2'b01,
        CWL_STANDBY = 2'b10,
        CWL_HALT    = 2'b11
    } cwl_state_type;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cwl_bus_req_type;

    typedef struct packed
    {
        logic cpu_clock_en;
        logic sys_clock_en;
        logic osc_pll_en;
    } cwl_gate_type;

endpackage

// File: verification/cwl_watchdog_lpm_props.sv
`timescale 1ns/1ps
`default_nettype none

module cwl_watchdog_lpm_props
(
    input wire logic                     sys_clk,
    input wire logic                     reset,
    input wire logic                     osc_tick,
    input wire logic                     input_clock_lost,
    input wire logic                     wdog_clock_source,
    input wire logic                     wdog_reset_pulse_n,
    input wire logic                     wdog_wake_interrupt,
    input wire logic                     interrupt_expansion_wd,
    input wire logic                     limp_clock_sel,
    input wire cwl_pkg::cwl_gate_type    clock_gates,
    input wire logic                     peripheral_run,
    input wire logic                     debug_port_run,
    input wire logic [1:0]               lowpower_state
);
    import cwl_pkg::*;
    // ticks seen while the reset pulse is low; too long a pulse just wraps
    logic [9:0] low_ticks;
    always_ff @(posedge sys_clk)
    begin
        if (reset || wdog_reset_pulse_n)
            low_ticks <= 10'h000;
        else if (osc_tick)
            low_ticks <= low_ticks + 10'h001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_pulse_exact_len: assert property ($rose(wdog_reset_pulse_n) |-> low_ticks == 10'h200)
        else $error("reset pulse length wrong");
    a_pulse_after_tick: assert property ($fell(wdog_reset_pulse_n) |-> $past(osc_tick))
        else $error("reset pulse not caused by a tick");
    a_int_routed: assert property (wdog_wake_interrupt == interrupt_expansion_wd)
        else $error("interrupt copies differ");
    a_limp_follow: assert property (limp_clock_sel == $past(input_clock_lost))
        else $error("limp clock select late");
    a_debug_alive: assert property (debug_port_run)
        else $error("debug port stopped");
    a_idle_clocks: assert property (lowpower_state == 2'b01 |-> clock_gates == 3'b111)
        else $error("idle gated a clock");
    a_standby_clocks: assert property (lowpower_state == 2'b10 |->
        clock_gates == 3'b001 && !peripheral_run)
        else $error("standby gating wrong");
    a_halt_clocks: assert property (lowpower_state == 2'b11 |-> clock_gates == 3'b000)
        else $error("halt left a clock running");
    a_halt_wd_clock: assert property ($changed(lowpower_state) && lowpower_state == 2'b11
        |-> $past(wdog_clock_source))
        else $error("halt without watchdog clock");
endmodule

bind cwl_watchdog_lpm cwl_watchdog_lpm_props u_props
(
    .sys_clk(sys_clk), .reset(reset), .osc_tick(osc_tick), .input_clock_lost(input_clock_lost),
    .wdog_clock_source(wdog_clock_source), .wdog_reset_pulse_n(wdog_reset_pulse_n),
    .wdog_wake_interrupt(wdog_wake_interrupt), .interrupt_expansion_wd(interrupt_expansion_wd),
    .limp_clock_sel(limp_clock_sel), .clock_gates(clock_gates), .peripheral_run(peripheral_run),
    .debug_port_run(debug_port_run), .lowpower_state(lowpower_state)
);

`default_nettype wire

// File: verification/cwl_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module cwl_cpu_model
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic interrupt_expansion_wd,
    output var  logic cpu_int_pending
);
    // recognition takes a cycle, as a real core needs to sample its lines
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cpu_int_pending <= 1'b0;
        else
            cpu_int_pending <= interrupt_expansion_wd;
    end
endmodule

`default_nettype wire

// File: verification/cwl_watchdog_lpm_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cwl_cfg.svh"

module cwl_watchdog_lpm_tb;
    import cwl_pkg::*;
    logic sys_clk = 0, reset = 1, osc_tick = 0, limp_mode = 0, lost = 0, idle_instr = 0;
    logic debug_wake = 0, wd_src = 1, cpu_int, pulse_n, wd_int, pie_wd, wake;
    logic [31:0] rdata, gpio_a_n, v;
    logic [1:0] state;
    cwl_bus_req_type bus_req;
    int n_fail = 0, compares = 0, seed = 32'h68D2;

    cwl_watchdog_lpm dut
    (
        .sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(rdata),
        .osc_tick(osc_tick), .limp_mode(limp_mode), .input_clock_lost(lost),
        .idle_instr(idle_instr), .cpu_int_pending(cpu_int), .external_reset_pin_n(1'b1),
        .debug_wake(debug_wake), .wdog_clock_source(wd_src), .gpio_a_n(gpio_a_n),
        .wdog_reset_pulse_n(pulse_n), .wdog_wake_interrupt(wd_int),
        .interrupt_expansion_wd(pie_wd), .limp_clock_sel(), .clock_gates(),
        .peripheral_run(), .debug_port_run(), .lowpower_wake(wake), .lowpower_state(state)
    );
    cwl_cpu_model u_cpu
    (
        .sys_clk(sys_clk), .reset(reset), .interrupt_expansion_wd(pie_wd),
        .cpu_int_pending(cpu_int)
    );

    always #2.5 sys_clk = ~sys_clk;

    task summarize;
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 chk("read data", rdata, exp);
    endtask
    task tick(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            osc_tick <= 1'b1;
            @(posedge sys_clk);
            osc_tick <= 1'b0;
        end
        #1;
    endtask
    task key;
        wr(`CWL_ADDR_WD_KEY, {24'h00_0000, `CWL_KEY_FIRST});
        wr(`CWL_ADDR_WD_KEY, {24'h00_0000, `CWL_KEY_SECOND});
    endtask
    task sleep;
        @(posedge sys_clk);
        idle_instr <= 1'b1;
        @(posedge sys_clk);
        idle_instr <= 1'b0;
        #1;
    endtask
    task pin(input logic [31:0] p);
        @(posedge sys_clk);
        gpio_a_n <= p;
    endtask
    function logic [1:0] exp_state(input logic [1:0] m);
        return m[1] ? 2'b11 : {m[0], ~m[0]};
    endfunction

    initial
    begin
        #200us;
        n_fail++;
        summarize;
    end

    initial
    begin
        bus_req = '0;
        gpio_a_n = 32'hFFFF_FFFF;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`CWL_ADDR_WD_CTRL, 32'h0000_0000);
        rd(`CWL_ADDR_LP_CFG, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
        v = $random(seed);
        wr(`CWL_ADDR_WAKE_SEL, v);
        rd(`CWL_ADDR_WAKE_SEL, v);
        tick(10);
        // a foreign key value must spoil the pair
        wr(`CWL_ADDR_WD_KEY, {24'h00_0000, `CWL_KEY_FIRST});
        wr(`CWL_ADDR_WD_KEY, 32'h0000_0012);
        wr(`CWL_ADDR_WD_KEY, {24'h00_0000, `CWL_KEY_SECOND});
        rd(`CWL_ADDR_WD_STATUS, 32'h0000_000A);
        key;
        rd(`CWL_ADDR_WD_STATUS, 32'h0000_0000);
        @(posedge sys_clk);
        limp_mode <= 1'b1;
        lost <= 1'b1;
        tick(5);
        limp_mode <= 1'b0;
        lost <= 1'b0;
        rd(`CWL_ADDR_WD_STATUS, 32'h0000_0000);
        wr(`CWL_ADDR_WD_CTRL, 32'h0000_0001);
        tick(300);
        chk("reset pulse", pulse_n, 1'b1);
        wr(`CWL_ADDR_WD_CTRL, 32'h0000_0000);
        tick(255);
        chk("reset pulse", pulse_n, 1'b1);
        tick(1);
        chk("reset pulse", pulse_n, 1'b0);
        // counter held off so a second wrap cannot stretch the pulse
        wr(`CWL_ADDR_WD_CTRL, 32'h0000_0001);
        tick(511);
        chk("reset pulse", pulse_n, 1'b0);
        tick(1);
        @(posedge sys_clk);
        #1 chk("reset pulse", pulse_n, 1'b1);
        wr(`CWL_ADDR_WD_CTRL, 32'h0000_0002);
        key;
        tick(256);
        repeat (2) @(posedge sys_clk);
        #1 chk("wake interrupt", wd_int, 1'b1);
        chk("reset pulse", pulse_n, 1'b1);
        key;
        rd(`CWL_ADDR_WD_STATUS, 32'h0000_0000);
        wr(`CWL_ADDR_LP_CFG, 32'h0000_0000);
        sleep;
        chk("state", state, exp_state(2'b00));
        tick(256);
        repeat (4) @(posedge sys_clk);
        #1 chk("state", state, 2'b00);
        key;
        wr(`CWL_ADDR_WAKE_SEL, 32'h0000_0020);
        wr(`CWL_ADDR_LP_CFG, 32'h0000_000D);
        sleep;
        chk("state", state, exp_state(2'b01));
        pin(32'hFFFF_FFBF);
        tick(8);
        chk("state", state, 2'b10);
        pin(32'hFFFF_FFDF);
        tick(3);
        chk("state", state, 2'b10);
        pin(32'hFFFF_FFFF);
        tick(1);
        pin(32'hFFFF_FFDF);
        tick(3);
        chk("state", state, 2'b10);
        tick(1);
        repeat (2) @(posedge sys_clk);
        #1 chk("state", state, 2'b00);
        pin(32'hFFFF_FFFF);
        @(posedge sys_clk);
        wd_src <= 1'b0;
        wr(`CWL_ADDR_LP_CFG, 32'h0000_0002);
        sleep;
        chk("state", state, 2'b00);
        @(posedge sys_clk);
        wd_src <= 1'b1;
        sleep;
        chk("state", state, exp_state(2'b10));
        // halt must hold while no wake source is present
        repeat (3) @(posedge sys_clk);
        #1 chk("state", state, 2'b11);
        @(posedge sys_clk);
        debug_wake <= 1'b1;
        @(posedge sys_clk);
        #1 chk("wake pulse", wake, 1'b1);
        @(posedge sys_clk);
        debug_wake <= 1'b0;
        #1 chk("state", state, 2'b00);
        wr(`CWL_ADDR_LP_CFG, 32'h0000_0003);
        sleep;
        chk("state", state, exp_state(2'b11));
        repeat (3) @(posedge sys_clk);
        #1 chk("state", state, 2'b11);
        pin(32'hFFFF_FFDF);
        repeat (3) @(posedge sys_clk);
        gpio_a_n <= 32'hFFFF_FFFF;
        #1 chk("state", state, 2'b00);
        key;
        repeat (20)
        begin
            tick(1 + ($unsigned($random(seed)) % 200));
            key;
            rd(`CWL_ADDR_WD_STATUS, 32'h0000_0000);
        end
        summarize;
    end
endmodule

`default_nettype wire
